// ===== verif/cssi_card_model.sv
// Behavioural card in the socket: drives detect, ready, protect and battery pins.
// Assumes the bench sets contact and pin levels at the falling clock edge.
module cssi_card_model (
  input wire logic clock_i,      // System clock
  input wire logic [1:0] ins_i,  // Detect contacts made, bit 0 = detect 1
  input wire logic rdy_i,        // Ready level
  input wire logic wp_i,         // Write protect level
  input wire logic [1:0] bv_i,   // Battery pins, bit 0 = first
  output logic [1:0] cd_n_o,     // Detect pins, active low
  output logic rdy_o,            // Ready pin
  output logic wp_o,             // Write protect pin
  output logic [1:0] bv_o        // Battery pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0; // Pattern for undriven pins
  // Undriven lines change each cycle so no stale value is seen
  always @(posedge clock_i) tog <= ~tog;
  // Detect pins pulled up until contact is made
  assign cd_n_o = ~ins_i;
  // Card signals float when fully out of the socket
  assign rdy_o = (ins_i == 2'b00) ? tog : rdy_i;
  assign wp_o = (ins_i == 2'b00) ? ~tog : wp_i;
  assign bv_o = (ins_i == 2'b00) ? {tog, ~tog} : bv_i;
endmodule

// ===== verif/test_card_socket_status_irq.sv
// Self-checking bench for the per-slot socket block through indexed I/O.
// Assumes the card model file is compiled first.
module test_card_socket_status_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, resetn_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [7:0] io_wdata_i = 8'h00, io_rdata_o, d;
  logic io_rvalid_o, card_out_en_o, card_reset_o, sw_a, sw_b, chk_n, v, rdy, wp;
  logic [15:0] irq_o;
  logic [1:0] cd_n, bv, ins = 2'b00, c_bv = 2'b11;
  logic c_rdy = 1'b1, c_wp = 1'b1;
  int err_count = 0, n_compared = 0, cyc = 0;
  int hi5 = 0, h0 = 0; // Cycles seen with IRQ5 high, and a snapshot of it
  // Far side card
  cssi_card_model u_card (.clock_i(clock_i), .ins_i(ins), .rdy_i(c_rdy), .wp_i(c_wp), .bv_i(c_bv),
    .cd_n_o(cd_n), .rdy_o(rdy), .wp_o(wp), .bv_o(bv));
  cssi_socket u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .card_detect1_n_i(cd_n[0]), .card_detect2_n_i(cd_n[1]), .ready_busy_i(rdy), .write_protect_i(wp),
    .battery_sense_first_i(bv[0]), .battery_sense_second_i(bv[1]), .card_out_en_o(card_out_en_o),
    .card_reset_o(card_reset_o), .supply_switch_a_o(sw_a), .supply_switch_b_o(sw_b), .irq_o(irq_o),
    .channel_check_out_n_o(chk_n));
  // Clock, 10 ns period
  initial forever #5 clock_i = ~clock_i;
  // IRQ5 high-time counter, sampled where outputs are settled
  always @(negedge clock_i) begin
    if (irq_o[5] === 1'b1) hi5++;
  end
  // Hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  // Verdict and end of run
  task automatic conclude();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Register value compare
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pin group compare
  task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One host I/O cycle, strobe high across one rising edge
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] wd);
    @(negedge clock_i);
    io_addr_i = a;
    io_wdata_i = wd;
    io_wr_i = w;
    io_rd_i = ~w;
    @(negedge clock_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask
  // Index then data write, then let outputs follow
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    io(1'b1, cssi_pkg::INDEX_PORT, idx);
    io(1'b1, cssi_pkg::DATA_PORT, dat);
    repeat (3) @(negedge clock_i);
  endtask
  // Index write then data read; answer stands for the cycle after the read edge
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat, output logic vl);
    io(1'b1, cssi_pkg::INDEX_PORT, idx);
    io(1'b0, cssi_pkg::DATA_PORT, 8'h00);
    vl = io_rvalid_o;
    dat = io_rdata_o;
  endtask
  // Read and compare
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    rd(idx, d, v);
    chk_pin({nm, "_valid"}, 16'h0001, {15'h0000, v});
    chk_reg(nm, e, d);
  endtask
  // Card pin change, then time for events to land
  task automatic setp(input logic [1:0] i, input logic r, input logic [1:0] b);
    @(negedge clock_i);
    ins = i;
    c_rdy = r;
    c_bv = b;
    repeat (5) @(negedge clock_i);
  endtask
  // Output group: out_en, reset, switch a, switch b, check
  function automatic logic [15:0] outs();
    return {11'h000, card_out_en_o, card_reset_o, sw_a, sw_b, chk_n};
  endfunction
  // Main sequence
  initial begin
    repeat (20) @(negedge clock_i);
    resetn_i = 1'b1;
    @(negedge clock_i);
    chk_pin("outs_reset", 16'h0009, outs());
    chk_pin("irq_reset", 16'h0000, irq_o);
    rchk("pwr_reset", 8'h02, 8'h00);
    rchk("ctl_reset", 8'h03, 8'h00);
    rchk("cfg_reset", 8'h05, 8'h00);
    // Insert card, clear flags from floating pins
    setp(2'b11, 1'b1, 2'b11);
    rd(8'h04, d, v);
    rchk("status_in", 8'h01, 8'h3f);
    wr(8'h02, 8'h91);
    chk_pin("outs_on", 16'h0019, outs());
    rchk("status_pwr", 8'h01, 8'h7f);
    wr(8'h03, 8'h40);
    chk_pin("outs_run", 16'h0011, outs());
    // Partial removal with auto power drop
    wr(8'h02, 8'hb1);
    setp(2'b10, 1'b1, 2'b11);
    chk_pin("outs_part", 16'h0005, outs());
    rchk("status_part", 8'h01, 8'h3b);
    rchk("flags_cd", 8'h04, 8'h08);
    rchk("flags_clr", 8'h04, 8'h00);
    setp(2'b11, 1'b1, 2'b11);
    rd(8'h04, d, v);
    // Supply switch table with power enable off
    for (int c = 0; c < 4; c++) begin
      wr(8'h02, 8'(c));
      chk_pin("switch", (c == 1) ? 16'h2 : (c == 2) ? 16'h1 : 16'h0, {sw_a, sw_b});
    end
    // Ready rise raises IRQ5 until the flags are read
    wr(8'h05, 8'h5f);
    setp(2'b11, 1'b0, 2'b11);
    setp(2'b11, 1'b1, 2'b11);
    chk_pin("irq_rdy", 16'h0020, irq_o);
    rchk("flags_rdy", 8'h04, 8'h04);
    repeat (3) @(negedge clock_i);
    chk_pin("irq_clr", 16'h0000, irq_o);
    // Battery transitions
    setp(2'b11, 1'b1, 2'b01);
    rchk("flags_warn", 8'h04, 8'h02);
    setp(2'b11, 1'b1, 2'b00);
    rchk("flags_dead", 8'h04, 8'h01);
    setp(2'b11, 1'b1, 2'b10);
    rchk("flags_dead2", 8'h04, 8'h00);
    // Detect change gated, then enabled, then to channel check
    wr(8'h05, 8'h50);
    setp(2'b01, 1'b1, 2'b11);
    chk_pin("irq_gated", 16'h0000, irq_o);
    rd(8'h04, d, v);
    wr(8'h05, 8'h58);
    setp(2'b11, 1'b1, 2'b11);
    chk_pin("irq_cd", 16'h0020, irq_o);
    wr(8'h03, 8'h50);
    chk_pin("chk_on", 16'h0000, {irq_o[15:1], chk_n});
    rd(8'h04, d, v);
    repeat (3) @(negedge clock_i);
    chk_pin("chk_off", 16'h0001, {15'h0000, chk_n});
    // I/O mode: card request steering for every code
    setp(2'b11, 1'b0, 2'b11);
    for (int c = 0; c < 16; c++) begin
      wr(8'h03, 8'h60 | 8'(c));
      chk_pin("irq_code", (16'h0001 << c) & cssi_pkg::IRQ_LEGAL, irq_o);
    end
    setp(2'b11, 1'b0, 2'b10);
    rchk("status_io", 8'h01, 8'h1e);
    rchk("flags_sts", 8'h04, 8'h01);
    // Edge mode pulses once; write-back mode keeps flags over reads
    wr(8'h03, 8'h40);
    wr(8'h1e, 8'h06);
    h0 = hi5;
    setp(2'b01, 1'b1, 2'b11);
    chk_pin("edge_pulse", 16'h0001, 16'(hi5 - h0));
    chk_pin("edge_low", 16'h0000, irq_o);
    rchk("flags_wb", 8'h04, 8'h0c);
    wr(8'h04, 8'h08);
    rchk("flags_wb_clr", 8'h04, 8'h04);
    // Refused and unmapped accesses
    rd(8'h42, d, v);
    chk_pin("other_slot", 16'h0000, {15'h0000, v});
    rchk("unmapped", 8'h06, 8'h00);
    conclude();
  end
endmodule

// ===== verilog/cssi_change_detect.sv
// Card pin change detector: turns pin transitions into one-cycle events.
// Assumes card pins are already synchronous to clock_i.
module cssi_change_detect (
  input wire logic clock_i,     // System clock
  input wire logic resetn_i,    // Async reset, active low
  input wire logic cd1_n_i,     // Card detect 1, active low
  input wire logic cd2_n_i,     // Card detect 2, active low
  input wire logic ready_i,     // Ready/busy pin
  input wire logic first_i,     // Battery sense first / status change pin
  input wire logic second_i,    // Battery sense second pin
  input wire logic io_mode_i,   // I/O card mode
  output logic [3:0] event_o    // Change events, one-cycle pulses
);

  logic primed;                 // Previous samples are meaningful
  logic cd1_prev;               // Card detect 1 last cycle
  logic cd2_prev;               // Card detect 2 last cycle
  logic ready_prev;             // Ready last cycle
  logic first_prev;             // First battery pin last cycle
  cssi_pkg::cssi_batt_t batt_prev; // Battery condition last cycle
  cssi_pkg::cssi_batt_t batt_now;  // Battery condition now

  assign batt_now = cssi_pkg::batt_decode(first_i, second_i);

  // Sample history, first cycle after reset only primes it
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      primed <= 1'b0;
      cd1_prev <= 1'b1;
      cd2_prev <= 1'b1;
      ready_prev <= 1'b0;
      first_prev <= 1'b0;
      batt_prev <= cssi_pkg::BATT_DEAD;
    end else begin
      primed <= 1'b1;
      cd1_prev <= cd1_n_i;
      cd2_prev <= cd2_n_i;
      ready_prev <= ready_i;
      first_prev <= first_i;
      batt_prev <= batt_now;
    end
  end

  // Event decode
  always_comb begin
    event_o = 4'h0;
    if (primed) begin
      // Either detect pin, either direction
      event_o[cssi_pkg::CHG_CD_BIT] = (cd1_prev != cd1_n_i) || (cd2_prev != cd2_n_i);
      if (io_mode_i) begin
        // Status change pin, any change
        event_o[cssi_pkg::CHG_DEAD_BIT] = first_prev != first_i;
      end else begin
        // Ready rising edge, memory mode only
        event_o[cssi_pkg::CHG_RDY_BIT] = !ready_prev && ready_i;
        // Entry into warning
        event_o[cssi_pkg::CHG_WARN_BIT] = (batt_now == cssi_pkg::BATT_WARN) && (batt_prev != cssi_pkg::BATT_WARN);
        // Entry into dead
        event_o[cssi_pkg::CHG_DEAD_BIT] = (batt_now == cssi_pkg::BATT_DEAD) && (batt_prev != cssi_pkg::BATT_DEAD);
      end
    end
  end

endmodule

// ===== verilog/cssi_pkg.sv
// Constants, types and shared decoders for the card socket status block.
// Assumes one slot per instance and an ISA-style indexed I/O register port.
package cssi_pkg;

  // Host I/O ports of the indexed register access
  localparam logic [15:0] INDEX_PORT = 16'h03e0; // Index write port
  localparam logic [15:0] DATA_PORT = 16'h03e1;  // Data read/write port

  // Register offsets inside one slot window
  localparam logic [5:0] OFS_IF_STATUS = 6'h01;   // socket_interface_status
  localparam logic [5:0] OFS_PWR_CTL = 6'h02;     // card_power_control
  localparam logic [5:0] OFS_IRQ_CTL = 6'h03;     // irq_and_card_control
  localparam logic [5:0] OFS_CHG_FLAGS = 6'h04;   // status_change_flags
  localparam logic [5:0] OFS_CHG_CFG = 6'h05;     // status_change_irq_config
  localparam logic [5:0] OFS_GLOBAL_CTL = 6'h1e;  // Global control

  // Reset values
  localparam logic [7:0] RST_CTL = 8'h00;         // All control registers
  localparam logic [7:0] RST_INDEX = 8'h00;       // Index register

  // Power control fields
  localparam int PWR_OUT_EN_BIT = 7;    // Card output enable
  localparam int PWR_AUTO_BIT = 5;      // Drop power when card absent
  localparam int PWR_ENABLE_BIT = 4;    // Card power enable
  // Interrupt and card control fields
  localparam int CTL_RESET_N_BIT = 6;   // 0 holds card in reset
  localparam int CTL_IO_MODE_BIT = 5;   // 1 = I/O card mode
  localparam int CTL_CHK_EN_BIT = 4;    // Route change interrupt to channel check
  // Status change flag and enable positions
  localparam int CHG_CD_BIT = 3;        // Card detect change
  localparam int CHG_RDY_BIT = 2;       // Ready change
  localparam int CHG_WARN_BIT = 1;      // Battery warning
  localparam int CHG_DEAD_BIT = 0;      // Battery dead or status change
  // Global control fields
  localparam int GC_EDGE_BIT = 1;       // 1 = pulsed interrupt outputs
  localparam int GC_WRITE_BACK_BIT = 2; // 1 = flags cleared by writing ones

  // Lines that a steering code may select
  localparam logic [15:0] IRQ_LEGAL = 16'hdeb8;

  // Decoded battery condition
  typedef enum logic [1:0] {BATT_DEAD, BATT_WARN, BATT_GOOD} cssi_batt_t;

  // Battery pin pair to condition
  function automatic cssi_batt_t batt_decode(input logic first, input logic second);
    if (!first) begin
      return BATT_DEAD;
    end else if (!second) begin
      return BATT_WARN;
    end
    return BATT_GOOD;
  endfunction

  // Steering code to one-hot line, zero for unusable codes
  function automatic logic [15:0] irq_decode(input logic [3:0] code);
    logic [15:0] hot;
    hot = 16'h0001 << code;
    return hot & IRQ_LEGAL;
  endfunction

endpackage

// ===== verilog/cssi_socket.sv
// Per-slot socket status, power, reset and interrupt steering logic.
// Assumes host I/O strobes and card pins are synchronous to clock_i.
//
// Contract
// - Status bit 6 shows card supplies active.
// - Status bits 5,4 follow ready, write protect.
// - Status bits 3,2 read 1 on detect low.
// - Memory mode: bits 1,0 follow battery pins.
// - I/O mode: bits 1,0 show speaker, status change.
// - Battery pins decode dead, warning, good.
// - Inserted only when both detects are low.
// - Drive card outputs only when enabled, inserted.
// - Supply switches from bits 1:0, off when active.
// - Card reset while control bit 6 is 0.
// - Control bit 5 selects I/O card mode.
// - Control bit 4 routes change interrupt to check.
// - Bits 3:0 steer card request to IRQ.
// - Flag 3 on any card detect change.
// - Flag 2 on ready rising edge in memory mode.
// - Flag 1 on entering battery warning in memory mode.
// - Flag 0 on entering dead, or status change.
// - Reading flags clears them unless write-back mode.
// - Config bit 3 gates card detect interrupts.
// - Config bits 2..0 gate ready, warning, dead.
// - Change interrupt uses config bits 7:4 as code; check overrides.
// - Interrupt outputs are edge or level.
module cssi_socket #(
  parameter logic [7:0] SLOT_BASE = 8'h00       // Index base of this slot
) (
  input wire logic clock_i,                     // System clock, 100 MHz
  input wire logic resetn_i,                    // Async reset, active low
  input wire logic [15:0] io_addr_i,            // Host I/O address
  input wire logic io_wr_i,                     // Host I/O write strobe
  input wire logic io_rd_i,                     // Host I/O read strobe
  input wire logic [7:0] io_wdata_i,            // Host write data
  output logic [7:0] io_rdata_o,                // Host read data
  output logic io_rvalid_o,                     // Read data valid pulse
  input wire logic card_detect1_n_i,            // Card detect 1, active low
  input wire logic card_detect2_n_i,            // Card detect 2, active low
  input wire logic ready_busy_i,                // Ready/busy, request in I/O mode
  input wire logic write_protect_i,             // Write protect pin
  input wire logic battery_sense_first_i,       // Battery sense 1 / status change
  input wire logic battery_sense_second_i,      // Battery sense 2 / speaker_status
  output logic card_out_en_o,                   // Card-side outputs driven
  output logic card_reset_o,                    // Card reset, active high
  output logic supply_switch_a_o,               // Card supply switch A
  output logic supply_switch_b_o,               // Card supply switch B
  output logic [15:0] irq_o,                    // ISA interrupt lines
  output logic channel_check_out_n_o            // Channel check, active low
);

  logic [7:0] index;             // Selected register index
  logic [7:0] pwr_ctl;           // card_power_control
  logic [7:0] irq_ctl;           // irq_and_card_control
  logic [3:0] chg_flags;         // status_change_flags
  logic [7:0] chg_cfg;           // status_change_irq_config
  logic [7:0] global_ctl;        // Global control
  logic [3:0] events;            // Change events this cycle
  logic inserted;                // Card fully seated
  logic pwr_active;              // Supplies active status
  logic io_mode;                 // I/O card mode
  logic in_slot;                 // Index falls in this slot
  logic [5:0] ofs;               // Offset inside slot window
  logic data_wr;                 // Write to data port for this slot
  logic data_rd;                 // Read from data port for this slot
  logic [7:0] status_now;        // Live interface status
  logic [7:0] next_rdata;        // Read mux result
  logic flags_rd_clear;          // Flags cleared by this read
  logic [3:0] flags_wr_clear;    // Flags cleared by write-back
  logic chg_pending;             // Enabled change flag present
  logic card_req;                // Card interrupt request active
  logic [15:0] next_irq_level;   // Interrupt levels before edge mode
  logic next_chk_level;          // Channel check level
  logic [15:0] irq_level_prev;   // Levels last cycle
  logic chk_level_prev;          // Check level last cycle

  // Card pin change events
  cssi_change_detect u_detect (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .cd1_n_i(card_detect1_n_i),
    .cd2_n_i(card_detect2_n_i),
    .ready_i(ready_busy_i),
    .first_i(battery_sense_first_i),
    .second_i(battery_sense_second_i),
    .io_mode_i(io_mode),
    .event_o(events)
  );

  // Socket condition
  assign inserted = !card_detect1_n_i && !card_detect2_n_i;
  assign pwr_active = pwr_ctl[cssi_pkg::PWR_ENABLE_BIT] &&
                      !(pwr_ctl[cssi_pkg::PWR_AUTO_BIT] && !inserted);
  assign io_mode = irq_ctl[cssi_pkg::CTL_IO_MODE_BIT];

  // Host access decode: index port then data port
  assign in_slot = index[7:6] == SLOT_BASE[7:6];
  assign ofs = index[5:0];
  assign data_wr = io_wr_i && (io_addr_i == cssi_pkg::DATA_PORT) && in_slot;
  assign data_rd = io_rd_i && (io_addr_i == cssi_pkg::DATA_PORT) && in_slot;

  // Live status assembly
  always_comb begin
    status_now = 8'h00;
    status_now[6] = pwr_active;
    status_now[5] = ready_busy_i;
    status_now[4] = write_protect_i;
    status_now[3] = !card_detect2_n_i;
    status_now[2] = !card_detect1_n_i;
    // Same pins, meaning set by card mode
    status_now[1] = battery_sense_second_i;
    status_now[0] = battery_sense_first_i;
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (ofs)
      cssi_pkg::OFS_IF_STATUS: next_rdata = status_now;
      cssi_pkg::OFS_PWR_CTL: next_rdata = pwr_ctl;
      cssi_pkg::OFS_IRQ_CTL: next_rdata = irq_ctl;
      cssi_pkg::OFS_CHG_FLAGS: next_rdata = {4'h0, chg_flags};
      cssi_pkg::OFS_CHG_CFG: next_rdata = chg_cfg;
      cssi_pkg::OFS_GLOBAL_CTL: next_rdata = global_ctl;
      default: next_rdata = 8'h00;
    endcase
  end

  // Flag clearing paths
  assign flags_rd_clear = data_rd && (ofs == cssi_pkg::OFS_CHG_FLAGS) &&
                          !global_ctl[cssi_pkg::GC_WRITE_BACK_BIT];
  assign flags_wr_clear = (data_wr && (ofs == cssi_pkg::OFS_CHG_FLAGS) &&
                           global_ctl[cssi_pkg::GC_WRITE_BACK_BIT]) ? io_wdata_i[3:0] : 4'h0;

  // Index register, written through the index port
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      index <= cssi_pkg::RST_INDEX;
    end else if (io_wr_i && (io_addr_i == cssi_pkg::INDEX_PORT)) begin
      index <= io_wdata_i;
    end
  end

  // Control registers, all cleared by reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_ctl <= cssi_pkg::RST_CTL;
      irq_ctl <= cssi_pkg::RST_CTL;
      chg_cfg <= cssi_pkg::RST_CTL;
      global_ctl <= cssi_pkg::RST_CTL;
    end else if (data_wr) begin
      unique case (ofs)
        cssi_pkg::OFS_PWR_CTL: pwr_ctl <= io_wdata_i;
        cssi_pkg::OFS_IRQ_CTL: irq_ctl <= io_wdata_i;
        cssi_pkg::OFS_CHG_CFG: chg_cfg <= io_wdata_i;
        cssi_pkg::OFS_GLOBAL_CTL: global_ctl <= io_wdata_i;
        default: ;                             // Read-only or unmapped
      endcase
    end
  end

  // Sticky change flags, a new event wins over a clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chg_flags <= 4'h0;
    end else if (flags_rd_clear) begin
      chg_flags <= events;
    end else begin
      chg_flags <= (chg_flags & ~flags_wr_clear) | events;
    end
  end

  // Read data register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= data_rd;
      if (data_rd) begin
        io_rdata_o <= next_rdata;
      end
    end
  end

  // Card outputs, reset and supply switches
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      card_out_en_o <= 1'b0;
      card_reset_o <= 1'b1;
      supply_switch_a_o <= 1'b0;
      supply_switch_b_o <= 1'b0;
    end else begin
      card_out_en_o <= pwr_ctl[cssi_pkg::PWR_ENABLE_BIT] &&
                       pwr_ctl[cssi_pkg::PWR_OUT_EN_BIT] && inserted;
      card_reset_o <= !irq_ctl[cssi_pkg::CTL_RESET_N_BIT];
      // Codes 01 and 10 pick one switch, forced off while active
      supply_switch_a_o <= !pwr_active && (pwr_ctl[1:0] == 2'b01);
      supply_switch_b_o <= !pwr_active && (pwr_ctl[1:0] == 2'b10);
    end
  end

  // Interrupt levels
  assign chg_pending = |(chg_flags & chg_cfg[3:0]);
  assign card_req = io_mode && !ready_busy_i;        // Request is active low in I/O mode

  always_comb begin
    next_irq_level = 16'h0000;
    if (card_req) begin
      next_irq_level = cssi_pkg::irq_decode(irq_ctl[3:0]);
    end
    if (chg_pending && !irq_ctl[cssi_pkg::CTL_CHK_EN_BIT]) begin
      next_irq_level = next_irq_level | cssi_pkg::irq_decode(chg_cfg[7:4]);
    end
    next_chk_level = chg_pending && irq_ctl[cssi_pkg::CTL_CHK_EN_BIT];
  end

  // Interrupt outputs, level or one-cycle pulse on rise
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_level_prev <= 16'h0000;
      chk_level_prev <= 1'b0;
      irq_o <= 16'h0000;
      channel_check_out_n_o <= 1'b1;
    end else begin
      irq_level_prev <= next_irq_level;
      chk_level_prev <= next_chk_level;
      if (global_ctl[cssi_pkg::GC_EDGE_BIT]) begin
        irq_o <= next_irq_level & ~irq_level_prev;
        channel_check_out_n_o <= !(next_chk_level && !chk_level_prev);
      end else begin
        irq_o <= next_irq_level;
        channel_check_out_n_o <= !next_chk_level;
      end
    end
  end

  // Card outputs only follow a seated, enabled card
  property p_out_en;
    @(posedge clock_i) disable iff (!resetn_i)
    card_out_en_o |-> $past(inserted && pwr_ctl[7] && pwr_ctl[4]);
  endproperty
  a_out_en: assert property (p_out_en) else $error("card outputs enabled without card or enable");

  // Switches off the cycle after power is active
  property p_supply;
    @(posedge clock_i) disable iff (!resetn_i)
    $past(pwr_active) |-> !supply_switch_a_o && !supply_switch_b_o;
  endproperty
  a_supply: assert property (p_supply) else $error("supply switch on while power active");

  // Reset bit low holds card reset
  property p_card_reset;
    @(posedge clock_i) disable iff (!resetn_i)
    !irq_ctl[6] [*2] |-> card_reset_o;
  endproperty
  a_card_reset: assert property (p_card_reset) else $error("card reset not asserted");

  // Detect change shows in flag 3 two cycles later
  property p_cd_flag;
    @(posedge clock_i) disable iff (!resetn_i)
    ($changed(card_detect1_n_i) || $changed(card_detect2_n_i)) && $past(resetn_i) |=> ##1 chg_flags[3];
  endproperty
  a_cd_flag: assert property (p_cd_flag) else $error("card detect change not flagged");

  // Clearing read empties flags when nothing new arrives
  property p_rd_clear;
    @(posedge clock_i) disable iff (!resetn_i)
    flags_rd_clear && (events == 4'h0) |=> (chg_flags == 4'h0) ##0 (io_rdata_o[3:0] == $past(chg_flags));
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read");

  // Only usable lines ever assert
  property p_irq_legal;
    @(posedge clock_i) disable iff (!resetn_i)
    (irq_o & ~cssi_pkg::IRQ_LEGAL) == 16'h0000;
  endproperty
  a_irq_legal: assert property (p_irq_legal) else $error("unselectable interrupt line asserted");

  // Routed change interrupt reaches channel check in level mode
  property p_chk_route;
    @(posedge clock_i) disable iff (!resetn_i)
    chg_pending && irq_ctl[4] && !global_ctl[1] |=> !channel_check_out_n_o;
  endproperty
  a_chk_route: assert property (p_chk_route) else $error("channel check not asserted");

  // Level mode holds the change line while pending
  property p_level_hold;
    @(posedge clock_i) disable iff (!resetn_i)
    chg_pending && !irq_ctl[4] && !global_ctl[1] && (chg_cfg[7:4] == 4'h5) |=> irq_o[5];
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("change interrupt not held");

  // Edge mode output lasts one cycle
  property p_edge_pulse;
    @(posedge clock_i) disable iff (!resetn_i)
    global_ctl[1] && $past(global_ctl[1]) && irq_o[5] |=> !irq_o[5];
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge mode pulse too long");

endmodule
